// file: verification/mac_irq_mdio_addr_regs_bench.sv
// Purpose: Bus tests of mirq_regs
// Assumes: PHY model on the data pin
// Notes: All byte lanes enabled except for one OFF_ADDR_LO write with lane 0 only
module mac_irq_mdio_addr_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import mirq_pkg::*;
  logic clk;
  logic rst_b;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] evt;
  logic [3:0] be;
  logic mdio_o, mdio_oe, mdc_o, line, ctrl_irq, irq;
  logic [47:0] station_addr;
  int fail_count = 0;
  int cmp_count = 0;
  logic [31:0] pw[4] = '{32'h0000_0006, 32'h0000_0002, 32'h0000_0000, 32'h0000_0001};
  logic [31:0] pr[4] = '{32'h0000_000e, 32'h0000_0002, 32'h0000_0008, 32'h0000_0001};
  mirq_regs dut_u (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(be), .avs_readdata, .avs_waitrequest, .link_change_evt(evt[2]),
    .wake_packet_evt(evt[1]), .bad_carrier_evt(evt[0]), .mdio_i(line), .mdio_o,
    .mdio_oe, .mdc_o, .station_addr, .ctrl_irq, .irq);
  mirq_phy_model phy_u (.mdc(mdc_o), .mdio_o, .mdio_oe, .mdio_line(line));
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest && n < 20);
    q = avs_readdata;
    if (avs_waitrequest) begin
      fail_count++;
      $display("[FAIL] waitrequest expected 0 seen 1");
      conclude();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : acc
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0000_0000, q);
    chk("readdata", {16'h0000, e}, {16'h0000, q});
  endtask : rdc
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    evt = 3'h0;
    be = 4'hf;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rdc(OFF_IRQ_EN, 32'h0000_0000);
    rdc(OFF_ADDR_HI, 32'h0000_0000);
    rdc(OFF_PORT, 32'h0000_0008);
    rdc(OFF_EVT, 32'h0000_0000);
    wr(OFF_IRQ_EN, 32'h0000_0007);
    rdc(OFF_IRQ_EN, 32'h0000_0007);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_IRQ_EN, 32'h0000_0007 ^ (32'h0000_0001 << i));
      @(posedge clk);
      evt <= 3'h1 << i;
      @(posedge clk);
      evt <= 3'h0;
      repeat (3) @(posedge clk);
      chk("ctrl_irq", 48'h0, ctrl_irq);
      wr(OFF_IRQ_EN, 32'h0000_0001 << i);
      chk("ctrl_irq", 48'h1, ctrl_irq);
      wr(OFF_STATUS, 32'h0000_0000);
      rdc(OFF_STATUS, 32'h0000_0001 << i);
      wr(OFF_STATUS, 32'h0000_0001 << i);
      chk("ctrl_irq", 48'h0, ctrl_irq);
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFF_PORT, pw[i]);
      chk("pins", pw[i][2:0], {mdio_o, mdio_oe, mdc_o});
      rdc(OFF_PORT, pr[i]);
    end
    wr(OFF_EVT_MASK, 32'h0000_0001);
    chk("irq", 48'h1, irq);
    rdc(OFF_EVT, 32'h0000_0003);
    chk("irq", 48'h0, irq);
    wr(OFF_EVT_MASK, 32'h0000_0000);
    wr(OFF_PORT, 32'h0000_0000);
    chk("irq", 48'h0, irq);
    rdc(OFF_EVT, 32'h0000_0001);
    wr(OFF_ADDR_HI, 32'h0123_4567);
    wr(OFF_ADDR_LO, 32'h0000_89ab);
    rdc(OFF_ADDR_HI, 32'h0123_4567);
    chk("station_addr", 48'h0123_4567_89ab, station_addr);
    be <= 4'h1;
    wr(OFF_ADDR_LO, 32'h0000_00cd);
    be <= 4'hf;
    rdc(OFF_ADDR_LO, 32'h0000_89cd);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk("station_addr", 48'h0, station_addr);
    rdc(OFF_IRQ_EN, 32'h0000_0000);
    wr(OFF_ADDR_HI, 32'h0a0b_0c0d);
    wr(OFF_ADDR_LO, 32'h0000_0e0f);
    chk("station_addr", 48'h0a0b_0c0d_0e0f, station_addr);
    rdc(6'h3c, 32'h0000_0000);
    conclude();
  end
endmodule : mac_irq_mdio_addr_regs_bench

// file: verification/mirq_phy_model.sv
// Purpose: PHY on the management pins
// Assumes: Drives the data line while released
// Notes: Shifts read data on clock rise
module mirq_phy_model (
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  output logic mdio_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sh_r = 16'ha5c3;
  always @(posedge mdc) begin
    if (!mdio_oe) begin
      sh_r <= {sh_r[14:0], sh_r[15]};
    end
  end
  assign mdio_line = mdio_oe ? mdio_o : sh_r[15];
endmodule : mirq_phy_model

// file: verification/mirq_regs_checker.sv
// Purpose: Port assertions for mirq_regs
// Assumes: One clock, sync reset
// Notes: Bound to mirq_regs
module mirq_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic mdc_o,
  input wire logic [47:0] station_addr,
  input wire logic ctrl_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import mirq_pkg::*;
  logic wr;
  logic pw;
  logic rd;
  assign wr = avs_write && !avs_waitrequest;
  assign pw = wr && avs_address == OFF_PORT;
  assign rd = avs_read && !avs_waitrequest;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  AST_MDC: assert property (pw |-> ##2 mdc_o == $past(avs_writedata[0], 2))
    else $error("mdc_o");
  AST_DIR: assert property (pw |-> ##2 mdio_oe == $past(avs_writedata[1], 2))
    else $error("mdio_oe");
  AST_DOUT: assert property (pw |-> ##2 mdio_o == $past(avs_writedata[2], 2))
    else $error("mdio_o");
  AST_REL: assert property ($fell(mdio_oe) |-> $past(pw && !avs_writedata[1], 2))
    else $error("release");
  AST_ADDR: assert property (wr && avs_address == OFF_ADDR_HI |->
    ##2 station_addr[47:16] == $past(avs_writedata, 2)) else $error("addr");
  AST_PORT_HI: assert property (rd && avs_address == OFF_PORT |->
    !(|avs_readdata[31:4])) else $error("port high bits");
  AST_IE_HI: assert property (rd && avs_address == OFF_IRQ_EN |->
    !(|avs_readdata[31:3])) else $error("enable high bits");
  AST_CIRQ: assert property ($fell(ctrl_irq) |-> $past(wr, 2))
    else $error("ctrl_irq");
endmodule : mirq_chk
bind mirq_regs mirq_chk chk_u (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .mdio_o, .mdio_oe, .mdc_o,
  .station_addr, .ctrl_irq);

// file: verilog/mirq_pin_if.sv
// Purpose: Carries the management pin levels between the top and the pin stage
// Assumes: Single clock domain
// Notes: Synchronised data level travels back to the top
interface mirq_pin_if;
  logic clk_level;
  logic dir_level;
  logic dout_level;
  logic din_sync;
  modport ctrl (output clk_level, output dir_level, output dout_level, input din_sync);
  modport pins (input clk_level, input dir_level, input dout_level, output din_sync);
endinterface : mirq_pin_if

// file: verilog/mirq_pin_stage.sv
// Purpose: Registers management pin outputs and synchronises the data pin
// Assumes: Data pin arrives asynchronously
// Notes: Output enable high while the pin is driven
module mirq_pin_stage (
  input wire logic clk,
  input wire logic rst_b,
  mirq_pin_if.pins pif,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  output logic mdc_o
);
  import mirq_pkg::*;
  logic meta_r;
  logic sync_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mdc_o <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end else begin
      mdc_o <= pif.clk_level;
      mdio_o <= pif.dout_level;
      mdio_oe <= pif.dir_level;
    end
  end

  always_ff @(posedge clk) begin
    meta_r <= mdio_i;
    sync_r <= meta_r;
  end

  assign pif.din_sync = sync_r;
endmodule : mirq_pin_stage

// file: verilog/mirq_pkg.sv
// Purpose: Constants for the MAC interrupt-enable, management port and station address bank
// Assumes: Avalon-MM word addressing by byte address, 32-bit data
// Notes: Offsets are byte addresses of aligned words
package mirq_pkg;
  localparam logic [5:0] OFF_STATUS = 6'h00;
  localparam logic [5:0] OFF_IRQ_EN = 6'h04;
  localparam logic [5:0] OFF_PORT = 6'h08;
  localparam logic [5:0] OFF_ADDR_HI = 6'h0c;
  localparam logic [5:0] OFF_ADDR_LO = 6'h10;
  localparam logic [5:0] OFF_EVT = 6'h14;
  localparam logic [5:0] OFF_EVT_MASK = 6'h18;
  localparam int FLAG_BAD_CARRIER = 0;
  localparam int FLAG_WAKE_PACKET = 1;
  localparam int FLAG_LINK_CHANGE = 2;
  localparam int PORT_CLK = 0;
  localparam int PORT_DIR = 1;
  localparam int PORT_DOUT = 2;
  localparam int PORT_DIN = 3;
  localparam int EVT_MDC_EDGE = 0;
  localparam int EVT_MDI_CHANGE = 1;
  localparam logic [2:0] RST_FLAGS = 3'h0;
  localparam logic [2:0] RST_PORT = 3'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_ADDR_LO = 16'h0000;
  localparam logic [1:0] RST_EVT = 2'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;
  typedef enum logic [1:0] {
    MIRQ_IDLE,
    MIRQ_ACK
  } mirq_bus_state_type;
endpackage : mirq_pkg

// file: verilog/mirq_regs.sv
// Purpose: Interrupt-enable, management bit-bang and station address registers
// Assumes: Avalon-MM slave, one wait state per access
// Notes: Unmapped reads return zero, unmapped writes are dropped
//
// The register addresses and register access over Avalon-MM were decided locally.
module mirq_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic link_change_evt,
  input wire logic wake_packet_evt,
  input wire logic bad_carrier_evt,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  output logic mdc_o,
  output logic [47:0] station_addr,
  output logic ctrl_irq,
  output logic irq
);
  import mirq_pkg::*;

  mirq_pin_if pif ();
  mirq_bus_state_type state_r;
  logic [2:0] flags_r;
  logic [2:0] irq_en_r;
  logic [2:0] port_r;
  logic [31:0] addr_hi_r;
  logic [15:0] addr_lo_r;
  logic [1:0] evt_r;
  logic [1:0] evt_mask_r;
  logic din_prev_r;
  logic mdc_prev_r;
  logic [31:0] rd_nxt;
  logic [31:0] wmask;
  logic wr_go;
  logic rd_go;
  logic [1:0] evt_set;
  logic [31:0] irq_en_nxt;
  logic [31:0] port_nxt;
  logic [31:0] addr_lo_nxt;
  logic [31:0] evt_mask_nxt;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  assign wmask = lane_mask(avs_byteenable);
  assign wr_go = (state_r == MIRQ_ACK) && avs_write;
  assign rd_go = (state_r == MIRQ_ACK) && avs_read;

  // Merged write words, sliced to each register's width
  assign irq_en_nxt = merge({29'h0, irq_en_r}, avs_writedata, wmask);
  assign port_nxt = merge({29'h0, port_r}, avs_writedata, wmask);
  assign addr_lo_nxt = merge({16'h0, addr_lo_r}, avs_writedata, wmask);
  assign evt_mask_nxt = merge({30'h0, evt_mask_r}, avs_writedata, wmask);

  // Bus handshake: one wait cycle, then acknowledge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= MIRQ_IDLE;
    end else begin
      case (state_r)
        MIRQ_IDLE: begin
          if (avs_read || avs_write) begin
            state_r <= MIRQ_ACK;
          end
        end
        MIRQ_ACK: state_r <= MIRQ_IDLE;
        default: state_r <= MIRQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((state_r == MIRQ_IDLE) && (avs_read || avs_write));
    end
  end

  // Controller status flags: set wins over write-one clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags_r <= RST_FLAGS;
    end else begin
      flags_r <= (flags_r & ~((wr_go && avs_address == OFF_STATUS) ?
                  (avs_writedata[2:0] & wmask[2:0]) : 3'h0))
                 | {link_change_evt, wake_packet_evt, bad_carrier_evt};
    end
  end

  // Interrupt enables
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_en_r <= RST_FLAGS;
    end else if (wr_go && avs_address == OFF_IRQ_EN) begin
      irq_en_r <= irq_en_nxt[2:0];
    end
  end

  // Management bit-bang port
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      port_r <= RST_PORT;
    end else if (wr_go && avs_address == OFF_PORT) begin
      port_r <= port_nxt[2:0];
    end
  end

  // Station address
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addr_hi_r <= RST_WORD;
      addr_lo_r <= RST_ADDR_LO;
    end else if (wr_go && avs_address == OFF_ADDR_HI) begin
      addr_hi_r <= merge(addr_hi_r, avs_writedata, wmask);
    end else if (wr_go && avs_address == OFF_ADDR_LO) begin
      addr_lo_r <= addr_lo_nxt[15:0];
    end
  end

  // Pin events: management clock edge and data-in change
  assign evt_set = {pif.din_sync != din_prev_r, port_r[PORT_CLK] != mdc_prev_r};

  // Follows the synced level through reset, so no false edge after reset
  always_ff @(posedge clk) begin
    din_prev_r <= pif.din_sync;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mdc_prev_r <= 1'b0;
    end else begin
      mdc_prev_r <= port_r[PORT_CLK];
    end
  end

  // Sticky events, cleared by reading; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      evt_r <= RST_EVT;
    end else begin
      // Only the bits handed out by this read are cleared
      evt_r <= (evt_r & ~((rd_go && avs_address == OFF_EVT) ? avs_readdata[1:0] : 2'h0))
               | evt_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      evt_mask_r <= RST_EVT;
    end else if (wr_go && avs_address == OFF_EVT_MASK) begin
      evt_mask_r <= evt_mask_nxt[1:0];
    end
  end

  // Read mux, reserved bits zero
  always_comb begin
    rd_nxt = UNMAPPED_VALUE;
    case (avs_address)
      OFF_STATUS: rd_nxt = {29'h0, flags_r};
      OFF_IRQ_EN: rd_nxt = {29'h0, irq_en_r};
      OFF_PORT: rd_nxt = {28'h0, pif.din_sync, port_r};
      OFF_ADDR_HI: rd_nxt = addr_hi_r;
      OFF_ADDR_LO: rd_nxt = {16'h0, addr_lo_r};
      OFF_EVT: rd_nxt = {30'h0, evt_r};
      OFF_EVT_MASK: rd_nxt = {30'h0, evt_mask_r};
      default: rd_nxt = UNMAPPED_VALUE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_readdata <= ZERO_WORD;
    end else if ((state_r == MIRQ_IDLE) && avs_read) begin
      avs_readdata <= rd_nxt;
    end
  end

  // Interrupt outputs and registered station address
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_irq <= 1'b0;
      irq <= 1'b0;
      station_addr <= {RST_WORD, RST_ADDR_LO};
    end else begin
      ctrl_irq <= |(flags_r & irq_en_r);
      irq <= |(evt_r & evt_mask_r);
      station_addr <= {addr_hi_r, addr_lo_r};
    end
  end

  assign pif.clk_level = port_r[PORT_CLK];
  assign pif.dir_level = port_r[PORT_DIR];
  assign pif.dout_level = port_r[PORT_DOUT];

  mirq_pin_stage u_pins (
    .clk(clk),
    .rst_b(rst_b),
    .pif(pif),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe),
    .mdc_o(mdc_o)
  );
endmodule : mirq_regs
